/* rtl/dioc_filt_if.sv */
interface dioc_filt_if;
  logic raw;
  logic [dioc_pkg::CNT_W-1:0] limit;
  logic level;
  modport filt (input raw, input limit, output level);
  modport ctrl (output raw, output limit, input level);
endinterface

/* rtl/dioc_filter.sv */
module dioc_filter (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Channel
  dioc_filt_if.filt fi
);
  logic [2:0] sync_reg;
  logic [dioc_pkg::CNT_W-1:0] cnt_reg;
  logic level_reg;
  logic stable;
  logic differ;
  logic done;

  assign stable = sync_reg[1] == sync_reg[2];
  assign differ = sync_reg[2] != level_reg;
  assign done = cnt_reg == fi.limit - dioc_pkg::CNT_W'(1);

  // Pin crosses three flops; only the second and third are compared
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sync_reg <= 3'h0;
    end else begin
      sync_reg <= {sync_reg[1:0], fi.raw};
    end
  end

  // Any bounce restarts the count, so the new level must hold the full interval
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= '0;
    end else if (!(stable && differ) || done) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + dioc_pkg::CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      level_reg <= 1'b0;
    end else if (stable && differ && done) begin
      level_reg <= sync_reg[2];
    end
  end

  assign fi.level = level_reg;

  a_filt_settle: assert property (@(posedge sys_clk) disable iff (!nrst)
    (level_reg != $past(level_reg)) |->
      ($past(cnt_reg) == $past(fi.limit) - dioc_pkg::CNT_W'(1)) && $past(stable))
    else $error("filter level changed before the interval elapsed");

  a_filt_restart: assert property (@(posedge sys_clk) disable iff (!nrst)
    (differ && !stable) |=> (cnt_reg == '0) && $stable(level_reg))
    else $error("filter count not restarted on bounce");
endmodule

/* rtl/dioc_pkg.sv */
// Summary of operation
// - Control bit 0 clear: output bit 7 reads collective error; set: output 8 read-back.
// - Control bit 1 clear: fault switches off its own output; set: all outputs off.
// - Control bits 3:2 pick the output error filter interval from the four settings.
// - Control register resets to 1: read-back on bit 7, single shutdown, longest filter.
// - Low input filter register: two bits per input 1..4, input 1 at bits 1:0.
// - High input filter register: two bits per input 5..8, input 5 at bits 1:0.
// - Filter code 00 1.5-2.0 ms, 01 0.4-0.5 ms, 10 about 0.1 ms, 11 0.02 ms.
// - Output drive register bit set energises that output; output 1 at bit 0.
// - Collective error bit 7 stays set until software writes any value to it.
package dioc_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int CNT_W = 15;
  localparam int NUM_CH = 17;
  localparam int FAULT_BASE = 8;
  localparam int SENSE_CH = 16;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_INPUT_STATE = 8'h64;
  localparam logic [7:0] IDX_OUTPUT_DRIVE = 8'h65;
  localparam logic [7:0] IDX_OUTPUT_ERROR = 8'h66;
  localparam logic [7:0] IDX_IO_CONTROL = 8'h67;
  localparam logic [7:0] IDX_INPUT_FILTER_LOW = 8'h68;
  localparam logic [7:0] IDX_INPUT_FILTER_HIGH = 8'h69;

  localparam logic [7:0] CTRL_RESET = 8'h01;
  localparam logic [7:0] CTRL_MASK = 8'h0F;
  localparam logic [7:0] FILT_RESET = 8'h00;
  localparam logic [7:0] ERR_MASK = 8'h80;
  localparam int CTRL_BIT7_SEL = 0;
  localparam int CTRL_ALL_OFF = 1;
  localparam int CTRL_ERR_FILT = 2;
  localparam int ERR_BIT = 7;
  localparam int SENSE_BIT = 7;
  localparam logic [1:0] SEL_FASTEST = 2'h3;

  // Interval lower bounds in ns; counts round up to whole clocks
  localparam int CLK_NS = 50;
  localparam int T_SLOW_NS = 1500000;
  localparam int T_MID_NS = 400000;
  localparam int T_SHORT_NS = 100000;
  localparam int T_FAST_NS = 20000;
  localparam int SLOW_CYC = (T_SLOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int MID_CYC = (T_MID_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [CNT_W-1:0] SHORT_CYC = CNT_W'((T_SHORT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] FAST_CYC = CNT_W'((T_FAST_NS + CLK_NS - 1) / CLK_NS);

  function automatic logic [CNT_W-1:0] dioc_limit(input logic [1:0] sel,
                                                  input logic [CNT_W-1:0] slow,
                                                  input logic [CNT_W-1:0] mid);
    logic [CNT_W-1:0] r;
    case (sel)
      2'h0: r = slow;
      2'h1: r = mid;
      2'h2: r = SHORT_CYC;
      default: r = FAST_CYC;
    endcase
    return r;
  endfunction
endpackage

/* rtl/dioc_top.sv */
module dioc_top #(
  parameter int unsigned SLOW_CYC = dioc_pkg::SLOW_CYC,
  parameter int unsigned MID_CYC = dioc_pkg::MID_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dioc_pkg::ADDR_W-1:0] paddr,
  input wire logic [dioc_pkg::DATA_W-1:0] pwdata,
  output logic [dioc_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Field pins
  input wire logic [7:0] din,
  input wire logic [7:0] out_fault,
  input wire logic out8_sense,
  output logic [7:0] dout
);
  localparam logic [dioc_pkg::CNT_W-1:0] SLOW_LIM = dioc_pkg::CNT_W'(SLOW_CYC);
  localparam logic [dioc_pkg::CNT_W-1:0] MID_LIM = dioc_pkg::CNT_W'(MID_CYC);

  logic [7:0] ctrl_reg;
  logic [7:0] filt_lo_reg;
  logic [7:0] filt_hi_reg;
  logic [7:0] drive_reg;
  logic [7:0] drive_next;
  logic [7:0] off_reg;
  logic [7:0] off_next;
  logic err_reg;
  logic [7:0] dout_reg;
  logic [dioc_pkg::DATA_W-1:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [dioc_pkg::NUM_CH-1:0] lvl;
  logic [7:0] in_lvl;
  logic [7:0] fault_lvl;
  logic coll_err;
  logic sense_lvl;
  logic setup;
  logic wr_acc;
  logic hit;
  logic [7:0] idx;
  logic [7:0] rd_val;

  assign in_lvl = lvl[7:0];
  assign fault_lvl = lvl[dioc_pkg::SENSE_CH-1:dioc_pkg::FAULT_BASE];
  assign sense_lvl = lvl[dioc_pkg::SENSE_CH];
  assign coll_err = |fault_lvl;

  // One filter per input, per output fault, and for the output 8 read-back
  for (genvar ch = 0; ch < dioc_pkg::NUM_CH; ch++) begin : g_ch
    dioc_filt_if fif ();
    if (ch < 4) begin : g_lo
      assign fif.raw = din[ch];
      assign fif.limit = dioc_pkg::dioc_limit(filt_lo_reg[2*ch +: 2], SLOW_LIM, MID_LIM);
    end else if (ch < dioc_pkg::FAULT_BASE) begin : g_hi
      assign fif.raw = din[ch];
      assign fif.limit = dioc_pkg::dioc_limit(filt_hi_reg[2*(ch-4) +: 2], SLOW_LIM, MID_LIM);
    end else if (ch < dioc_pkg::SENSE_CH) begin : g_flt
      assign fif.raw = out_fault[ch-dioc_pkg::FAULT_BASE];
      assign fif.limit = dioc_pkg::dioc_limit(
        ctrl_reg[dioc_pkg::CTRL_ERR_FILT +: 2], SLOW_LIM, MID_LIM);
    end else begin : g_sns
      assign fif.raw = out8_sense;
      assign fif.limit = dioc_pkg::dioc_limit(dioc_pkg::SEL_FASTEST, SLOW_LIM, MID_LIM);
    end
    assign lvl[ch] = fif.level;
    dioc_filter u_filt (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .fi(fif.filt)
    );
  end

  // APB decode; zero wait states, so every access phase completes at once
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite && pready_reg;
  assign idx = paddr[9:2];
  assign hit = (paddr[1:0] == 2'h0) && (paddr[dioc_pkg::ADDR_W-1:10] == 2'h0) &&
               (idx >= dioc_pkg::IDX_INPUT_STATE) && (idx <= dioc_pkg::IDX_INPUT_FILTER_HIGH);

  always_comb begin
    rd_val = 8'h00;
    case (idx)
      dioc_pkg::IDX_INPUT_STATE: rd_val = in_lvl;
      dioc_pkg::IDX_OUTPUT_DRIVE: rd_val = {ctrl_reg[dioc_pkg::CTRL_BIT7_SEL] ? sense_lvl
                                            : coll_err, drive_reg[6:0]};
      dioc_pkg::IDX_OUTPUT_ERROR: rd_val = err_reg ? dioc_pkg::ERR_MASK : 8'h00;
      dioc_pkg::IDX_IO_CONTROL: rd_val = ctrl_reg;
      dioc_pkg::IDX_INPUT_FILTER_LOW: rd_val = filt_lo_reg;
      dioc_pkg::IDX_INPUT_FILTER_HIGH: rd_val = filt_hi_reg;
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      prdata_reg <= '0;
      pslverr_reg <= 1'b0;
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= 1'b1;
      if (setup) begin
        prdata_reg <= (hit && !pwrite) ? {24'h000000, rd_val} : '0;
        pslverr_reg <= !hit;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= dioc_pkg::CTRL_RESET;
      filt_lo_reg <= dioc_pkg::FILT_RESET;
      filt_hi_reg <= dioc_pkg::FILT_RESET;
    end else if (wr_acc && hit) begin
      if (idx == dioc_pkg::IDX_IO_CONTROL) begin
        ctrl_reg <= pwdata[7:0] & dioc_pkg::CTRL_MASK;
      end
      if (idx == dioc_pkg::IDX_INPUT_FILTER_LOW) begin
        filt_lo_reg <= pwdata[7:0];
      end
      if (idx == dioc_pkg::IDX_INPUT_FILTER_HIGH) begin
        filt_hi_reg <= pwdata[7:0];
      end
    end
  end

  // Shutdown latches until software writes the error register; a fault still
  // present then re-latches at once because the set wins
  always_comb begin
    drive_next = drive_reg;
    if (wr_acc && hit && idx == dioc_pkg::IDX_OUTPUT_DRIVE) begin
      drive_next = pwdata[7:0];
    end
    off_next = off_reg;
    if (wr_acc && hit && idx == dioc_pkg::IDX_OUTPUT_ERROR) begin
      off_next = 8'h00;
    end
    if (ctrl_reg[dioc_pkg::CTRL_ALL_OFF] && coll_err) begin
      off_next = 8'hFF;
    end else begin
      off_next = off_next | fault_lvl;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      drive_reg <= 8'h00;
      off_reg <= 8'h00;
      dout_reg <= 8'h00;
    end else begin
      drive_reg <= drive_next;
      off_reg <= off_next;
      dout_reg <= drive_next & ~off_next;
    end
  end

  // Error flag powers up set, as after any power-on the supply state is unknown
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      err_reg <= 1'b1;
    end else if (coll_err) begin
      err_reg <= 1'b1;
    end else if (wr_acc && hit && idx == dioc_pkg::IDX_OUTPUT_ERROR) begin
      err_reg <= 1'b0;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign dout = dout_reg;

  sequence s_read_drive;
    setup && !pwrite && hit && idx == dioc_pkg::IDX_OUTPUT_DRIVE;
  endsequence

  a_bit7_error: assert property (@(posedge sys_clk) disable iff (!nrst)
    (s_read_drive and !ctrl_reg[dioc_pkg::CTRL_BIT7_SEL]) |=>
      prdata_reg[dioc_pkg::SENSE_BIT] == $past(coll_err))
    else $error("output bit 7 does not show collective error");

  a_bit7_sense: assert property (@(posedge sys_clk) disable iff (!nrst)
    (s_read_drive and ctrl_reg[dioc_pkg::CTRL_BIT7_SEL]) |=>
      prdata_reg[dioc_pkg::SENSE_BIT] == $past(sense_lvl))
    else $error("output bit 7 does not show output 8 read-back");

  a_all_off: assert property (@(posedge sys_clk) disable iff (!nrst)
    (ctrl_reg[dioc_pkg::CTRL_ALL_OFF] && coll_err) |=> dout_reg == 8'h00)
    else $error("outputs not all switched off on fault");

  // In single shutdown mode with no output yet off, a faulty subset must switch off exactly those outputs and leave the rest driven
  a_single_off: assert property (@(posedge sys_clk) disable iff (!nrst)
    (!ctrl_reg[dioc_pkg::CTRL_ALL_OFF] && fault_lvl != 8'h00 && off_reg == 8'h00) |=>
      dout_reg == (drive_reg & ~$past(fault_lvl)))
    else $error("single-output shutdown wrong");

  a_err_interval: assert property (@(posedge sys_clk) disable iff (!nrst)
    ctrl_reg[3:2] == 2'h3 |-> g_ch[dioc_pkg::FAULT_BASE].fif.limit == dioc_pkg::FAST_CYC)
    else $error("error filter interval not selected");

  a_ctrl_reset: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(nrst) |-> ctrl_reg == dioc_pkg::CTRL_RESET && err_reg)
    else $error("control register reset value wrong");

  a_in_field: assert property (@(posedge sys_clk) disable iff (!nrst)
    (filt_lo_reg[7:6] == 2'h2 |-> g_ch[3].fif.limit == dioc_pkg::SHORT_CYC) and
    (filt_hi_reg[1:0] == 2'h0 |-> g_ch[4].fif.limit == SLOW_LIM))
    else $error("input filter field mapping wrong");

  a_drive_write: assert property (@(posedge sys_clk) disable iff (!nrst)
    (wr_acc && hit && idx == dioc_pkg::IDX_OUTPUT_DRIVE && off_reg == 8'h00 && !coll_err)
      |=> dout_reg == $past(pwdata[7:0]) ##1 dout_reg == $past(dout_reg) || coll_err
        || $past(coll_err) || $past(wr_acc))
    else $error("output drive write not applied");

  a_err_sticky: assert property (@(posedge sys_clk) disable iff (!nrst)
    (err_reg && !(wr_acc && hit && idx == dioc_pkg::IDX_OUTPUT_ERROR)) |=> err_reg)
    else $error("error flag cleared without a write");
endmodule

/* sim/digital_io_control_filters_test.sv */
module digital_io_control_filters_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] A_IN = {2'h0, dioc_pkg::IDX_INPUT_STATE, 2'h0};
  localparam logic [11:0] A_DRV = {2'h0, dioc_pkg::IDX_OUTPUT_DRIVE, 2'h0};
  localparam logic [11:0] A_ERR = {2'h0, dioc_pkg::IDX_OUTPUT_ERROR, 2'h0};
  localparam logic [11:0] A_CTL = {2'h0, dioc_pkg::IDX_IO_CONTROL, 2'h0};
  localparam logic [11:0] A_FLO = {2'h0, dioc_pkg::IDX_INPUT_FILTER_LOW, 2'h0};
  localparam logic [11:0] A_FHI = {2'h0, dioc_pkg::IDX_INPUT_FILTER_HIGH, 2'h0};
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] din;
  logic [7:0] out_fault;
  logic out8_sense;
  logic [7:0] dout;
  logic [7:0] din_cmd = 8'h00;
  logic [7:0] short_cmd = 8'h00;
  logic [31:0] rd;
  logic er;
  logic [7:0] v;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  int seed = 66;

  dioc_top #(.SLOW_CYC(20), .MID_CYC(10)) DUT (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .din(din), .out_fault(out_fault),
    .out8_sense(out8_sense), .dout(dout));
  dioc_field field (.din_cmd(din_cmd), .short_cmd(short_cmd), .dout(dout), .din(din),
    .out_fault(out_fault), .out8_sense(out8_sense));

  initial begin
    forever #25 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] rd_drive(input logic [7:0] drv, input logic sel,
                                           input logic err);
    return {24'h0, sel ? drv[7] : err, drv[6:0]};
  endfunction

  task chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Leading edge keeps two transfers from touching psel in one time step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rchk(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, rd, exp);
    chk("slave error", {31'h0, er}, 32'h0);
  endtask

  task end_sim();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      end_sim();
    end
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    chk("pready reset", {31'h0, pready}, 32'h0);
    chk("pslverr reset", {31'h0, pslverr}, 32'h0);
    chk("prdata reset", prdata, 32'h0);
    chk("dout reset", {24'h0, dout}, 32'h0);
    nrst <= 1'b1;
    rchk("io_control", A_CTL, 32'h01);
    rchk("filter_low", A_FLO, 32'h00);
    rchk("filter_high", A_FHI, 32'h00);
    rchk("error", A_ERR, 32'h80);
    rchk("drive", A_DRV, 32'h00);
    apb(1'b0, 12'h1A8, 32'h0);
    chk("unmapped err", {31'h0, er}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    // A misaligned write must be refused and leave the register alone
    apb(1'b1, A_CTL | 12'h001, 32'h0E);
    chk("misaligned err", {31'h0, er}, 32'h1);
    rchk("io_control kept", A_CTL, 32'h01);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      // Second pass puts codes 10 and 00 where the field assertions look
      v = (i == 0) ? 8'hE4 : (i == 1) ? 8'hBF : 8'($random(seed));
      apb(1'b1, A_FLO, {24'h0, v});
      rchk("filter_low", A_FLO, {24'h0, v});
      apb(1'b1, A_FHI, {24'h0, ~v});
      rchk("filter_high", A_FHI, {24'h0, ~v});
      apb(1'b1, A_CTL, {24'h0, v});
      rchk("io_control", A_CTL, {24'h0, v & 8'h0F});
    end
    $display("register test done");
    // Input 1 at the mid interval, input 5 at the fastest, the rest slowest
    apb(1'b1, A_FLO, 32'h01);
    apb(1'b1, A_FHI, 32'h03);
    din_cmd <= 8'hFF;
    repeat (15) @(posedge sys_clk);
    rchk("inputs mid", A_IN, 32'h01);
    repeat (20) @(posedge sys_clk);
    rchk("inputs slow", A_IN, 32'hEF);
    repeat (400) @(posedge sys_clk);
    rchk("inputs fast", A_IN, 32'hFF);
    $display("input filter test done");
    apb(1'b1, A_CTL, 32'h01);
    apb(1'b1, A_ERR, 32'($random(seed)));
    rchk("error clear", A_ERR, 32'h00);
    v = 8'($random(seed));
    apb(1'b1, A_DRV, {24'h0, v});
    repeat (2) @(posedge sys_clk);
    chk("dout", {24'h0, dout}, {24'h0, v});
    repeat (420) @(posedge sys_clk);
    rchk("drive sense", A_DRV, rd_drive(v, 1'b1, 1'b0));
    $display("drive test done");
    apb(1'b1, A_CTL, 32'h00);
    apb(1'b1, A_DRV, 32'h7C);
    short_cmd <= 8'h04;
    repeat (5) @(posedge sys_clk);
    chk("dout early", {24'h0, dout}, 32'h7C);
    repeat (30) @(posedge sys_clk);
    chk("dout single", {24'h0, dout}, 32'h78);
    rchk("error set", A_ERR, 32'h80);
    rchk("drive error", A_DRV, rd_drive(8'h7C, 1'b0, 1'b1));
    short_cmd <= 8'h00;
    // Filtered fault still present, so the flag must survive this write
    apb(1'b1, A_ERR, 32'h00);
    rchk("error held", A_ERR, 32'h80);
    // Let the fault filter release before the clear that should stick
    repeat (30) @(posedge sys_clk);
    apb(1'b1, A_ERR, 32'h00);
    rchk("error clear", A_ERR, 32'h00);
    repeat (2) @(posedge sys_clk);
    chk("dout restored", {24'h0, dout}, 32'h7C);
    apb(1'b1, A_CTL, 32'h06);
    short_cmd <= 8'h04;
    repeat (5) @(posedge sys_clk);
    chk("dout mid early", {24'h0, dout}, 32'h7C);
    repeat (20) @(posedge sys_clk);
    chk("dout all off", {24'h0, dout}, 32'h00);
    $display("fault test done");
    end_sim();
  end
endmodule

/* sim/dioc_field.sv */
module dioc_field (
  // Bench commands
  input wire logic [7:0] din_cmd,
  input wire logic [7:0] short_cmd,
  // Device pins
  input wire logic [7:0] dout,
  output logic [7:0] din,
  output logic [7:0] out_fault,
  output logic out8_sense
);
  timeunit 1ns;
  timeprecision 1ns;
  assign din = din_cmd;
  // A short only shows as a fault while its output is energised
  assign out_fault = short_cmd & dout;
  assign out8_sense = dout[7];
endmodule
